/* File: bfl_pkg.sv */
// Package: constants, types and register map of the buck mode and fault logic
package bfl_pkg;

	// ************************************************************
	// Register map (byte offsets on the plain register port)
	// ************************************************************
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_STICKY = 8'h04;
	localparam logic [7:0] ADDR_LIVE = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
	localparam logic [7:0] ADDR_CONFIG = 8'h14;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int UV_BIT = 0;
	localparam int OV_BIT = 1;
	localparam int MODE_LSB = 0;
	localparam int CFG_TON_LSB = 0;
	localparam int CFG_PFM_LSB = 2;
	localparam int CFG_SS_BIT = 4;
	localparam int CFG_ILIM_LSB = 5;
	localparam int CFG_SLOPE_LSB = 8;
	localparam int CFG_PINSEL_BIT = 14;
	localparam int CFG_EFFMODE_LSB = 16;

	// ************************************************************
	// Operating mode encoding
	// ************************************************************
	typedef enum logic [1:0] {
		BFL_MODE_PFM = 2'h0,
		BFL_MODE_RSV1 = 2'h1,
		BFL_MODE_RSV2 = 2'h2,
		BFL_MODE_PWM = 2'h3
	} bfl_mode_e;

	// Load sequencer: waiting for fuses, then running
	typedef enum logic [1:0] {
		BFL_ST_LOAD = 2'h0,
		BFL_ST_RUN = 2'h1
	} bfl_state_e;

	// ************************************************************
	// Timing (ns) and derived cycle counts at 250 MHz
	// ************************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TON_MIN_00_NS = 45;
	localparam int TON_MIN_01_NS = 65;
	localparam int TON_MIN_10_NS = 25;
	localparam int TON_MIN_11_NS = 45;
	localparam int PFM_TON_00_NS = 120;
	localparam int PFM_TON_01_NS = 210;
	localparam int PFM_TON_10_NS = 300;
	localparam int PFM_TON_11_NS = 550;
	localparam int SLOPE_MAX_MV_US = 1144;

	// Least times round up to whole cycles
	function automatic logic [7:0] ns_to_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (c < 1) begin
			c = 1;
		end
		return c[7:0];
	endfunction : ns_to_cyc

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [1:0] min_on_time_sel;
		logic [1:0] factory_op_mode_default;
		logic [1:0] light_load_on_time_sel;
		logic soft_start_time_sel;
		logic [1:0] current_limit_sel;
		logic [5:0] slope_comp_code;
		logic shared_pin_function_sel;
		logic overvolt_to_pg_a_en;
		logic overvolt_to_pg_b_en;
		logic undervolt_to_pg_a_en;
		logic undervolt_to_pg_b_en;
	} bfl_factory_s;

	typedef struct packed {
		logic [7:0] min_on_cycles;
		logic [7:0] pfm_on_cycles;
		logic soft_start_long;
		logic [1:0] current_limit_level;
		logic [5:0] slope_comp_code;
		bfl_mode_e op_mode;
		logic sync_clock_in;
	} bfl_ctrl_s;

	typedef struct packed {
		logic undervolt;
		logic overvolt;
	} bfl_fault_s;

endpackage : bfl_pkg

/* File: bfl_core.sv */
// Buck controller mode selection, configuration and fault-status logic
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Factory field selects high-side minimum on-time
// - Pin-function 0: pin is sync, register mode
// - Register mode initialised from factory default
// - Mode 00 PFM, 11 PWM, others reserved
// - Pin-function 1: pin low PWM, high PFM
// - Factory field selects PFM pulse on-time
// - Soft-start ramp time from one factory bit
// - Four-level cycle-by-cycle current limit, auto recovery
// - Six-bit monotonic slope compensation code
// - Feedback compare flags overvoltage and undervoltage
// - Overvoltage routed to power-good A and B
// - Undervoltage routed to power-good A and B
// - Sticky flags latch detected faults
// - Writing 1 clears a sticky flag
// - Live status bits follow present faults

module bfl_core (
	input wire logic clk, // 250 MHz clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire bfl_pkg::bfl_factory_s factory, // Factory fuse values
	input wire logic factory_valid, // Fuse values ready to load
	input wire logic mode_or_sync_pin, // Shared mode / sync pin
	input wire logic fb_over_ref, // Feedback above high threshold
	input wire logic fb_under_ref, // Feedback below low threshold
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output bfl_pkg::bfl_ctrl_s ctrl, // Settings to the analog loop
	output logic loaded, // Factory fields taken
	output logic power_good_out_a, // Power-good A fault assert
	output logic power_good_out_b, // Power-good B fault assert
	output logic irq // Level interrupt
);

	// ************************************************************
	// Factory load sequencing
	// ************************************************************
	bfl_pkg::bfl_state_e state_q;
	bfl_pkg::bfl_factory_s fuse_q;
	logic [1:0] buck_op_mode_field_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= bfl_pkg::BFL_ST_LOAD;
		end else begin
			case (state_q)
				bfl_pkg::BFL_ST_LOAD: begin
					if (factory_valid) begin
						state_q <= bfl_pkg::BFL_ST_RUN;
					end
				end
				bfl_pkg::BFL_ST_RUN: begin
					state_q <= bfl_pkg::BFL_ST_RUN;
				end
				default: begin
					state_q <= bfl_pkg::BFL_ST_LOAD;
				end
			endcase
		end
	end

	wire logic load_now = (state_q == bfl_pkg::BFL_ST_LOAD) && factory_valid;

	// Captured once so a glitching fuse bus cannot disturb a running loop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fuse_q <= '0;
		end else if (load_now) begin
			fuse_q <= factory;
		end
	end

	// ************************************************************
	// Register helpers
	// ************************************************************
	wire logic wr_mode = reg_wr && (reg_addr == bfl_pkg::ADDR_MODE);
	wire logic wr_sticky = reg_wr && (reg_addr == bfl_pkg::ADDR_STICKY);
	wire logic wr_en = reg_wr && (reg_addr == bfl_pkg::ADDR_IRQ_EN);
	wire logic wr_clr = reg_wr && (reg_addr == bfl_pkg::ADDR_IRQ_CLR);

	// Reserved codes are refused on register writes; the factory default loads unchecked
	function automatic logic mode_legal(input logic [1:0] m);
		return (m == bfl_pkg::BFL_MODE_PFM) || (m == bfl_pkg::BFL_MODE_PWM);
	endfunction : mode_legal

	// ************************************************************
	// Operating mode
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			buck_op_mode_field_q <= bfl_pkg::BFL_MODE_PFM;
		end else if (load_now) begin
			buck_op_mode_field_q <= factory.factory_op_mode_default;
		end else if (wr_mode && state_q == bfl_pkg::BFL_ST_RUN &&
			mode_legal(reg_wdata[bfl_pkg::MODE_LSB +: 2])) begin
			buck_op_mode_field_q <= reg_wdata[bfl_pkg::MODE_LSB +: 2];
		end
	end

	bfl_pkg::bfl_mode_e eff_mode;
	always_comb begin
		if (fuse_q.shared_pin_function_sel) begin
			// Pin low forces PWM, high gives light-load PFM
			eff_mode = mode_or_sync_pin ? bfl_pkg::BFL_MODE_PFM
				: bfl_pkg::BFL_MODE_PWM;
		end else begin
			eff_mode = bfl_pkg::bfl_mode_e'(buck_op_mode_field_q);
		end
	end

	// ************************************************************
	// Timing decode
	// ************************************************************
	function automatic logic [7:0] min_on(input logic [1:0] s);
		case (s)
			2'h0: return bfl_pkg::ns_to_cyc(bfl_pkg::TON_MIN_00_NS);
			2'h1: return bfl_pkg::ns_to_cyc(bfl_pkg::TON_MIN_01_NS);
			2'h2: return bfl_pkg::ns_to_cyc(bfl_pkg::TON_MIN_10_NS);
			default: return bfl_pkg::ns_to_cyc(bfl_pkg::TON_MIN_11_NS);
		endcase
	endfunction : min_on

	function automatic logic [7:0] pfm_on(input logic [1:0] s);
		case (s)
			2'h0: return bfl_pkg::ns_to_cyc(bfl_pkg::PFM_TON_00_NS);
			2'h1: return bfl_pkg::ns_to_cyc(bfl_pkg::PFM_TON_01_NS);
			2'h2: return bfl_pkg::ns_to_cyc(bfl_pkg::PFM_TON_10_NS);
			default: return bfl_pkg::ns_to_cyc(bfl_pkg::PFM_TON_11_NS);
		endcase
	endfunction : pfm_on

	// Control outputs registered so the loop sees clean levels
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= '0;
		end else begin
			ctrl.min_on_cycles <= min_on(fuse_q.min_on_time_sel);
			ctrl.pfm_on_cycles <= pfm_on(fuse_q.light_load_on_time_sel);
			ctrl.soft_start_long <= fuse_q.soft_start_time_sel;
			ctrl.current_limit_level <= fuse_q.current_limit_sel;
			ctrl.slope_comp_code <= fuse_q.slope_comp_code;
			ctrl.op_mode <= eff_mode;
			ctrl.sync_clock_in <= !fuse_q.shared_pin_function_sel
				&& mode_or_sync_pin;
		end
	end

	assign loaded = (state_q == bfl_pkg::BFL_ST_RUN);

	// ************************************************************
	// Fault monitoring
	// ************************************************************
	bfl_pkg::bfl_fault_s live_q;
	logic [1:0] sticky_q;
	logic [1:0] irq_en_q;
	logic pg_a_q;
	logic pg_b_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			live_q <= '0;
		end else begin
			live_q.overvolt <= loaded && fb_over_ref;
			live_q.undervolt <= loaded && fb_under_ref;
		end
	end

	wire logic [1:0] live_vec = {live_q.overvolt, live_q.undervolt};

	// Set wins over clear so no fault event is lost
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sticky_q <= '0;
		end else begin
			sticky_q <= (sticky_q & ~((wr_sticky || wr_clr) ?
				reg_wdata[1:0] : 2'h0)) | live_vec;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_q <= '0;
		end else if (wr_en) begin
			irq_en_q <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pg_a_q <= 1'b0;
			pg_b_q <= 1'b0;
		end else begin
			pg_a_q <= (live_q.overvolt && fuse_q.overvolt_to_pg_a_en) ||
				(live_q.undervolt && fuse_q.undervolt_to_pg_a_en);
			pg_b_q <= (live_q.overvolt && fuse_q.overvolt_to_pg_b_en) ||
				(live_q.undervolt && fuse_q.undervolt_to_pg_b_en);
		end
	end

	assign power_good_out_a = pg_a_q;
	assign power_good_out_b = pg_b_q;
	assign irq = |(sticky_q & irq_en_q);

	// ************************************************************
	// Read path
	// ************************************************************
	// 00 mode field [1:0], reserved codes refused
	// 04 sticky flags, [0] under, [1] over, write 1 to clear
	// 08 live status, same layout, read only
	// 0c interrupt enable, same layout
	// 10 interrupt clear, write 1 to clear, reads as 0
	// 14 fuse image and effective mode, read only
	// Idle cycles return 0 so a late sampler sees a clear miss
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0;
		case (reg_addr)
			bfl_pkg::ADDR_MODE: rd_d[1:0] = buck_op_mode_field_q;
			bfl_pkg::ADDR_STICKY: rd_d[1:0] = sticky_q;
			bfl_pkg::ADDR_LIVE: rd_d[1:0] = live_vec;
			bfl_pkg::ADDR_IRQ_EN: rd_d[1:0] = irq_en_q;
			bfl_pkg::ADDR_CONFIG: begin
				rd_d[bfl_pkg::CFG_TON_LSB +: 2] = fuse_q.min_on_time_sel;
				rd_d[bfl_pkg::CFG_PFM_LSB +: 2] = fuse_q.light_load_on_time_sel;
				rd_d[bfl_pkg::CFG_SS_BIT] = fuse_q.soft_start_time_sel;
				rd_d[bfl_pkg::CFG_ILIM_LSB +: 2] = fuse_q.current_limit_sel;
				rd_d[bfl_pkg::CFG_SLOPE_LSB +: 6] = fuse_q.slope_comp_code;
				rd_d[bfl_pkg::CFG_PINSEL_BIT] = fuse_q.shared_pin_function_sel;
				rd_d[bfl_pkg::CFG_EFFMODE_LSB +: 2] = eff_mode;
			end
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? rd_d : 32'h0;
		end
	end

endmodule : bfl_core

/* File: bfl_fb_model.sv */
// Model of the feedback divider and comparators at the external stage
`timescale 1ns/1ps
module bfl_fb_model #(
	parameter int HI_PCT = 110,
	parameter int LO_PCT = 90
) (
	input wire logic [7:0] vout_pct, // Output level, percent of target
	output logic over, // Above the overvoltage threshold
	output logic under // Below the undervoltage threshold
);
	// Plain levels: the comparators have no hysteresis here
	assign over = vout_pct > HI_PCT;
	assign under = vout_pct < LO_PCT;
endmodule : bfl_fb_model

/* File: bfl_core_properties.sv */
// Concurrent checks on the ports of the buck mode and fault logic
`timescale 1ns/1ps
module bfl_core_checker (
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire bfl_pkg::bfl_factory_s factory, // Fuse values
	input wire logic mode_or_sync_pin, // Shared pin
	input wire logic fb_over_ref, // Over comparator
	input wire logic fb_under_ref, // Under comparator
	input wire logic reg_wr, // Write strobe
	input wire bfl_pkg::bfl_ctrl_s ctrl, // Loop settings
	input wire logic loaded, // Fuses taken
	input wire logic power_good_out_a, // Power-good A
	input wire logic power_good_out_b // Power-good B
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Fault reaches power-good two edges after the comparator
	a_pg_a_route:
	assert property ($past(loaded, 3) |-> power_good_out_a == $past(
		fb_over_ref & factory.overvolt_to_pg_a_en |
		fb_under_ref & factory.undervolt_to_pg_a_en, 2))
		else $error("power-good A route wrong");
	a_pg_b_route:
	assert property ($past(loaded, 3) |-> power_good_out_b == $past(
		fb_over_ref & factory.overvolt_to_pg_b_en |
		fb_under_ref & factory.undervolt_to_pg_b_en, 2))
		else $error("power-good B route wrong");
	a_pin_low_pwm:
	assert property (loaded && factory.shared_pin_function_sel &&
		!mode_or_sync_pin |=> ctrl.op_mode == bfl_pkg::BFL_MODE_PWM)
		else $error("pin low gave no forced PWM");
	a_pin_high_pfm:
	assert property (loaded && factory.shared_pin_function_sel &&
		mode_or_sync_pin |=> ctrl.op_mode == bfl_pkg::BFL_MODE_PFM)
		else $error("pin high gave no light-load mode");
	a_sync_pin_ignored:
	assert property ($past(loaded) && loaded && !reg_wr && !$past(reg_wr)
		&& !factory.shared_pin_function_sel |=> $stable(ctrl.op_mode))
		else $error("mode moved without a register write");
	a_mode_legal:
	assert property (loaded |-> ctrl.op_mode == bfl_pkg::BFL_MODE_PFM ||
		ctrl.op_mode == bfl_pkg::BFL_MODE_PWM)
		else $error("reserved mode code in use");
	a_config_held:
	assert property ($past(loaded, 2) |-> $stable(ctrl.min_on_cycles) &&
		$stable(ctrl.pfm_on_cycles) && $stable(ctrl.slope_comp_code))
		else $error("factory setting moved after load");
	a_loaded_stays:
	assert property (loaded |=> loaded)
		else $error("load flag dropped");
	a_ilim_level:
	assert property ($past(loaded, 2) |->
		ctrl.current_limit_level == factory.current_limit_sel)
		else $error("current limit level wrong");
endmodule : bfl_core_checker

bind bfl_core bfl_core_checker u_bfl_core_checker (.clk(clk),
	.reset_n(reset_n), .factory(factory),
	.mode_or_sync_pin(mode_or_sync_pin), .fb_over_ref(fb_over_ref),
	.fb_under_ref(fb_under_ref), .reg_wr(reg_wr), .ctrl(ctrl),
	.loaded(loaded), .power_good_out_a(power_good_out_a),
	.power_good_out_b(power_good_out_b));

/* File: bfl_core_test.sv */
// Self-checking bench for the buck mode and fault logic
`timescale 1ns/1ps
module bfl_core_test;
	logic clk, reset_n, factory_valid, pin, reg_wr, reg_rd;
	logic over, under, loaded, pg_a, pg_b, irq;
	logic [7:0] reg_addr, vout;
	logic [31:0] reg_wdata, reg_rdata;
	bfl_pkg::bfl_factory_s factory;
	bfl_pkg::bfl_ctrl_s ctrl;
	int errors, compares;
	int ton_ns[4] = '{45, 65, 25, 45};
	int pfm_ns[4] = '{120, 210, 300, 550};
	logic [1:0] mode_wr[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
	logic [1:0] mode_exp[4] = '{2'h3, 2'h3, 2'h0, 2'h0};
	bfl_fb_model u_bfl_fb_model (.vout_pct(vout), .over(over),
		.under(under));
	bfl_core u_bfl_core (.clk(clk), .reset_n(reset_n), .factory(factory),
		.factory_valid(factory_valid), .mode_or_sync_pin(pin),
		.fb_over_ref(over), .fb_under_ref(under), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ctrl(ctrl), .loaded(loaded),
		.power_good_out_a(pg_a), .power_good_out_b(pg_b), .irq(irq));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// ****************************************
	// Bus cycles and comparison
	// ****************************************
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	task automatic boot(bfl_pkg::bfl_factory_s f);
		@(posedge clk);
		reset_n <= 1'h0;
		factory_valid <= 1'h0;
		factory <= f;
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		factory_valid <= 1'h1;
		for (int i = 0; i < 20 && loaded !== 1'h1; i++) @(posedge clk);
		@(posedge clk);
		#1 chk(loaded, 1'h1);
	endtask : boot
	task automatic lvl(logic [7:0] v);
		@(posedge clk);
		vout <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask : lvl
	function automatic logic [31:0] cfg(bfl_pkg::bfl_factory_s f,
		logic [1:0] m);
		return {14'h0, m, 1'h0, f.shared_pin_function_sel,
			f.slope_comp_code, 1'h0, f.current_limit_sel,
			f.soft_start_time_sel, f.light_load_on_time_sel,
			f.min_on_time_sel};
	endfunction : cfg
	task automatic wrap_up;
		$display("Mismatches %0d, comparisons %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#20000;
		errors++;
		wrap_up();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		bfl_pkg::bfl_factory_s f;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reset_n = 1'h0;
		pin = 1'h0;
		vout = 8'h64;
		for (int i = 0; i < 4; i++) begin
			f = '0;
			f.min_on_time_sel = i[1:0];
			f.light_load_on_time_sel = i[1:0];
			f.current_limit_sel = i[1:0];
			f.factory_op_mode_default = {2{i[0]}};
			f.slope_comp_code = i[0] ? 6'h3f : 6'h00;
			f.soft_start_time_sel = i[0];
			boot(f);
			chk(ctrl.min_on_cycles, 32'((ton_ns[i] + 3) / 4));
			chk(ctrl.pfm_on_cycles, 32'((pfm_ns[i] + 3) / 4));
			chk(ctrl.soft_start_long, i[0]);
			chk(ctrl.current_limit_level, i[1:0]);
			chk(ctrl.slope_comp_code, f.slope_comp_code);
			rd(bfl_pkg::ADDR_MODE, {30'h0, {2{i[0]}}});
			rd(bfl_pkg::ADDR_CONFIG, cfg(f, {2{i[0]}}));
		end
		f = '0;
		f.overvolt_to_pg_a_en = 1'h1;
		f.undervolt_to_pg_b_en = 1'h1;
		boot(f);
		// Sync pin toggles meanwhile and must not touch the mode
		for (int j = 0; j < 4; j++) begin
			@(posedge clk) pin <= ~pin;
			wr(bfl_pkg::ADDR_MODE, {30'h0, mode_wr[j]});
			rd(bfl_pkg::ADDR_MODE, {30'h0, mode_exp[j]});
			chk(ctrl.op_mode, mode_exp[j]);
			chk(ctrl.sync_clock_in, pin);
		end
		lvl(8'h78);
		chk({pg_a, pg_b}, 2'h2);
		rd(bfl_pkg::ADDR_LIVE, 32'h2);
		lvl(8'h64);
		rd(bfl_pkg::ADDR_LIVE, 32'h0);
		rd(bfl_pkg::ADDR_STICKY, 32'h2);
		wr(bfl_pkg::ADDR_STICKY, 32'h0);
		rd(bfl_pkg::ADDR_STICKY, 32'h2);
		wr(bfl_pkg::ADDR_STICKY, 32'h2);
		rd(bfl_pkg::ADDR_STICKY, 32'h0);
		lvl(8'h50);
		chk({pg_a, pg_b}, 2'h1);
		rd(bfl_pkg::ADDR_LIVE, 32'h1);
		chk(irq, 1'h0);
		wr(bfl_pkg::ADDR_IRQ_EN, 32'h1);
		#1 chk(irq, 1'h1);
		wr(bfl_pkg::ADDR_IRQ_CLR, 32'h1);
		rd(bfl_pkg::ADDR_STICKY, 32'h1);
		lvl(8'h64);
		wr(bfl_pkg::ADDR_IRQ_CLR, 32'h1);
		#1 chk(irq, 1'h0);
		rd(8'hfc, 32'h0);
		// Pin mode: the bench leaves the mode field alone here
		f.shared_pin_function_sel = 1'h1;
		f.light_load_on_time_sel = 2'h2;
		boot(f);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk) pin <= k[0];
			repeat (3) @(posedge clk);
			#1 chk(ctrl.op_mode, k[0] ? 2'h0 : 2'h3);
			chk(ctrl.sync_clock_in, 1'h0);
		end
		rd(bfl_pkg::ADDR_CONFIG, cfg(f, 2'h0));
		@(posedge clk);
		factory.min_on_time_sel <= 2'h1;
		factory.slope_comp_code <= 6'h2a;
		repeat (3) @(posedge clk);
		#1 chk(ctrl.min_on_cycles, 32'h0c);
		chk(ctrl.slope_comp_code, 32'h0);
		wrap_up();
	end
endmodule : bfl_core_test
